// >>> bench/mic_core_model.sv
// Purpose: Core sequencer stand-in facing the interrupt controller
// Assumes: Service routine length fixed by ISR_LEN cycles
// Notes:   Bench clears flags inside that window, before the return
`timescale 1ns/1ps
module mic_core_model #(
    parameter int ISR_LEN = 40
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire mic_pkg::mic_core_t core_o,
    input wire logic [1:0] boundary_mode,
    output logic instr_boundary,
    output logic return_from_irq_instr,
    output logic [7:0] vec_cnt
);
    import mic_pkg::*;
    // ==========================================================
    // Instruction starts and service routine
    logic phase_reg;
    logic in_isr_reg;
    logic [7:0] isr_reg;
    // Mode 1 models two-cycle instructions, mode 2 a stalled core
    assign instr_boundary = (boundary_mode == 2'h0) ? 1'b1 :
                            (boundary_mode == 2'h1) ? phase_reg : 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= 1'b0;
            in_isr_reg <= 1'b0;
            isr_reg <= 8'h00;
            return_from_irq_instr <= 1'b0;
            vec_cnt <= 8'h00;
        end else begin
            phase_reg <= ~phase_reg;
            return_from_irq_instr <= 1'b0;
            if (core_o.vector_load) begin
                in_isr_reg <= 1'b1;
                isr_reg <= 8'(ISR_LEN);
                vec_cnt <= vec_cnt + 8'h01;
            end else if (in_isr_reg) begin
                if (isr_reg == 8'h00) begin
                    in_isr_reg <= 1'b0;
                    return_from_irq_instr <= 1'b1;
                end else begin
                    isr_reg <= isr_reg - 8'h01;
                end
            end
        end
    end
endmodule

// >>> bench/mic_top_bench.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero wait state bus, core model returns from every service
// Notes:   Comb core outputs are sampled on the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module mic_top_bench;
    import mic_pkg::*;
    localparam logic [31:0] A_CTRL = {20'h0, MIC_IDX_CTRL, 2'h0};
    localparam logic [31:0] A_PFLAG = {20'h0, MIC_IDX_PFLAG, 2'h0};
    localparam logic [31:0] A_PEN = {20'h0, MIC_IDX_PEN, 2'h0};
    localparam logic [31:0] A_OPT = {20'h0, MIC_IDX_OPT, 2'h0};
    localparam logic [31:0] A_STAT = {20'h0, MIC_IDX_STAT, 2'h0};
    localparam logic [31:0] A_NONE = 32'h0000_0100;
    localparam int PB [4] = '{0, 3, 6, 7};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_irq_pin, sleep_mode;
    logic instr_boundary, return_from_irq_instr;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, boundary_mode;
    logic [2:0] hsize;
    logic [5:0] gpio_in;
    logic [7:0] timer0_counter, vec_cnt;
    logic [12:0] vector_addr;
    mic_pevt_t periph_evt;
    mic_core_t core_o;
    int errors, n_compared;
    mic_top mic_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(3'h0), .hprot(4'h3),
        .hmastlock(1'b0), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(ext_irq_pin),
        .gpio_in(gpio_in), .timer0_counter(timer0_counter), .periph_evt(periph_evt),
        .instr_boundary(instr_boundary), .return_from_irq_instr(return_from_irq_instr),
        .sleep_mode(sleep_mode), .core_o(core_o), .vector_addr(vector_addr));
    mic_core_model mic_core_model_i (.hclk(hclk), .hresetn(hresetn), .core_o(core_o),
        .boundary_mode(boundary_mode), .instr_boundary(instr_boundary),
        .return_from_irq_instr(return_from_irq_instr), .vec_cnt(vec_cnt));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ==========================================================
    // Bus and wait tasks
    task automatic wrap_up();
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= MIC_HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic await_vec(input logic [7:0] v0);
        int n;
        n = 0;
        while (vec_cnt === v0) begin
            @(negedge hclk);
            n++;
            if (n > 50) begin
                errors++;
                wrap_up();
            end
        end
        @(posedge hclk);
    endtask
    // Flags cleared before the return, else the request comes straight back
    task automatic finish_isr(input logic [31:0] e, input logic [31:0] c);
        logic [31:0] q;
        int n;
        `CHK(vector_addr, MIC_VECTOR)
        rd(A_CTRL, e);
        wr(A_PFLAG, 32'h0);
        wr(A_CTRL, c);
        n = 0;
        q = 32'h0;
        while (q[MIC_GLB_EN] !== 1'b1) begin
            bus(1'b0, A_CTRL, 32'h0, q);
            n++;
            if (n > 40) begin
                errors++;
                wrap_up();
            end
        end
        `CHK(q, c | 32'h80)
    endtask
    task automatic wake_is(input logic e);
        @(negedge hclk);
        `CHK(core_o.wake, e)
        @(posedge hclk);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] v0;
        int k;
        logic pushed;
        {hresetn, hsel, hwrite, ext_irq_pin, sleep_mode} = '0;
        {haddr, hwdata, htrans, gpio_in, timer0_counter, boundary_mode} = '0;
        hsize = MIC_HSIZE_WORD;
        periph_evt = '0;
        errors = 0;
        n_compared = 0;
        tick(20);
        hresetn <= 1'b1;
        tick(2);
        rd(A_CTRL, 32'h0);
        rd(A_PFLAG, 32'h0);
        rd(A_OPT, 32'h40);
        wr(A_NONE, 32'hff);
        rd(A_NONE, 32'h0);
        wr(A_PEN, 32'hff);
        rd(A_PEN, 32'hc9);
        wr(A_PEN, 32'h0);
        ext_irq_pin <= 1'b1;
        tick(2);
        rd(A_CTRL, 32'h02);
        tick(20);
        rd(A_CTRL, 32'h02);
        timer0_counter <= 8'hff;
        tick(1);
        timer0_counter <= 8'h00;
        gpio_in <= 6'h01;
        tick(2);
        rd(A_CTRL, 32'h07);
        wr(A_CTRL, 32'h0);
        wr(A_OPT, 32'h0);
        ext_irq_pin <= 1'b0;
        tick(2);
        rd(A_CTRL, 32'h02);
        wr(A_CTRL, 32'h0);
        ext_irq_pin <= 1'b1;
        tick(2);
        rd(A_CTRL, 32'h0);
        wr(A_OPT, 32'h40);
        ext_irq_pin <= 1'b0;
        tick(2);
        rd(A_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            periph_evt <= mic_pevt_t'(4'h1 << i);
            tick(1);
            periph_evt <= '0;
            tick(1);
            rd(A_PFLAG, 32'h1 << PB[i]);
            wr(A_PFLAG, 32'h0);
            rd(A_PFLAG, 32'h0);
        end
        // ======================================================
        // Enables and vectoring
        v0 = vec_cnt;
        wr(A_CTRL, 32'h12);
        tick(10);
        `CHK(vec_cnt, v0)
        rd(A_STAT, 32'h0);
        wr(A_CTRL, 32'h82);
        tick(10);
        `CHK(vec_cnt, v0)
        wr(A_CTRL, 32'h0);
        for (int m = 0; m < 2; m++) begin
            boundary_mode <= 2'(m);
            wr(A_CTRL, 32'h90);
            ext_irq_pin <= 1'b1;
            k = 0;
            @(negedge hclk);
            pushed = 1'b0;
            while (core_o.vector_load !== 1'b1 && k < 10) begin
                pushed = core_o.push_ret;
                @(negedge hclk);
                k++;
            end
            `CHK(k >= 3 && k <= 4, 1'b1)
            `CHK(pushed, 1'b1)
            @(posedge hclk);
            ext_irq_pin <= 1'b0;
            finish_isr(32'h12, 32'h10);
            wr(A_CTRL, 32'h0);
        end
        `CHK(vec_cnt, 8'h02)
        boundary_mode <= 2'h2;
        v0 = vec_cnt;
        wr(A_CTRL, 32'h92);
        wr(A_CTRL, 32'h12);
        boundary_mode <= 2'h0;
        tick(10);
        `CHK(vec_cnt, v0)
        wr(A_CTRL, 32'h92);
        await_vec(v0);
        finish_isr(32'h12, 32'h10);
        wr(A_PEN, 32'h40);
        wr(A_CTRL, 32'hc0);
        v0 = vec_cnt;
        periph_evt <= mic_pevt_t'(4'h4);
        tick(1);
        periph_evt <= '0;
        await_vec(v0);
        finish_isr(32'h40, 32'h40);
        // ======================================================
        // Sleep, wake and a second reset
        wr(A_CTRL, 32'h10);
        sleep_mode <= 1'b1;
        wake_is(1'b0);
        ext_irq_pin <= 1'b1;
        tick(3);
        wake_is(1'b1);
        rd(A_STAT, 32'h4);
        v0 = vec_cnt;
        wr(A_CTRL, 32'h92);
        await_vec(v0);
        finish_isr(32'h12, 32'h10);
        sleep_mode <= 1'b0;
        hresetn <= 1'b0;
        tick(3);
        hresetn <= 1'b1;
        tick(2);
        rd(A_CTRL, 32'h0);
        wrap_up();
    end
endmodule

// >>> rtl/mic_ahb_port.sv
// Purpose: AHB-Lite address phase capture for the register file
// Assumes: Single word transfers, zero wait states
// Notes:   Misaligned or narrow writes are dropped, answer stays OKAY
`timescale 1ns/1ps
module mic_ahb_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic rd_take,
    output logic [9:0] rd_idx,
    output mic_pkg::mic_wr_t wr
);
    import mic_pkg::*;
    mic_wr_t wr_reg;
    wire addr_ok;
    wire take;

    assign take = hsel && htrans[1] && hready;
    assign addr_ok = (haddr[1:0] == 2'h0) && (hsize == MIC_HSIZE_WORD);
    assign rd_take = take && !hwrite;
    assign rd_idx = haddr[11:2];
    assign wr = wr_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= '0;
        end else begin
            wr_reg.valid <= take && hwrite && addr_ok;
            wr_reg.idx <= haddr[11:2];
        end
    end
endmodule

// >>> rtl/mic_event_detect.sv
// Purpose: Turns pin, port and timer levels into one-cycle events
// Assumes: Inputs synchronous to hclk
// Notes:   First cycle after reset only primes the history
`timescale 1ns/1ps
module mic_event_detect (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ext_irq_pin,
    input wire logic ext_edge_select,
    input wire logic [5:0] gpio_in,
    input wire logic [7:0] timer0_counter,
    output mic_pkg::mic_cevt_t evt
);
    import mic_pkg::*;
    logic primed_reg;
    logic pin_reg;
    logic [7:0] tmr_reg;
    logic [MIC_GPIO_W-1:0] gpio_reg;
    logic [MIC_GPIO_W-1:0] bit_chg;
    wire rise;
    wire fall;

    assign rise = ext_irq_pin && !pin_reg;
    assign fall = !ext_irq_pin && pin_reg;
    // ==========================================================
    // Per-bit port change
    genvar g;
    generate
        for (g = 0; g < MIC_GPIO_W; g++) begin : g_chg
            assign bit_chg[g] = gpio_in[g] ^ gpio_reg[g];
        end
    endgenerate

    assign evt.ext_edge = primed_reg && (ext_edge_select ? rise : fall);
    assign evt.port_change = primed_reg && (|bit_chg);
    assign evt.timer0_ovf = primed_reg && (tmr_reg == MIC_TMR_MAX)
        && (timer0_counter == MIC_TMR_MIN);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            primed_reg <= 1'b0;
            pin_reg <= 1'b0;
            tmr_reg <= MIC_TMR_MIN;
            gpio_reg <= '0;
        end else begin
            primed_reg <= 1'b1;
            pin_reg <= ext_irq_pin;
            tmr_reg <= timer0_counter;
            gpio_reg <= gpio_in;
        end
    end

    a_tmr_rollover: assert property (@(posedge hclk) disable iff (!hresetn)
        primed_reg && $past(timer0_counter) == MIC_TMR_MAX && timer0_counter == MIC_TMR_MIN
        |-> evt.timer0_ovf)
        else $error("timer0 rollover missed");
    a_ext_edge_dir: assert property (@(posedge hclk) disable iff (!hresetn)
        evt.ext_edge |-> (ext_irq_pin == ext_edge_select) && ($past(ext_irq_pin) != ext_irq_pin))
        else $error("external edge of wrong direction");
    a_port_change: assert property (@(posedge hclk) disable iff (!hresetn)
        primed_reg && (gpio_in != $past(gpio_in)) |-> evt.port_change)
        else $error("port change missed");
endmodule

// >>> rtl/mic_pkg.sv
// Purpose: Shared constants and types of the interrupt controller
// Assumes: AHB-Lite word registers, one core instruction cycle per clock
// Notes:   Byte address of a register is four times its index
package mic_pkg;
    // ==========================================================
    // Register indices and bus decode
    localparam logic [9:0] MIC_IDX_CTRL = 10'h00b;
    localparam logic [9:0] MIC_IDX_PFLAG = 10'h00c;
    localparam logic [9:0] MIC_IDX_PEN = 10'h08c;
    localparam logic [9:0] MIC_IDX_OPT = 10'h081;
    localparam logic [9:0] MIC_IDX_STAT = 10'h00f;
    localparam logic [2:0] MIC_HSIZE_WORD = 3'h2;
    localparam logic [1:0] MIC_HRESP_OKAY = 2'h0;
    localparam logic [31:0] MIC_RD_ZERO = 32'h0000_0000;
    // ==========================================================
    // Control register fields
    localparam int MIC_GLB_EN = 7;
    localparam int MIC_PEIE = 6;
    localparam int MIC_T0_EN = 5;
    localparam int MIC_EXT_EN = 4;
    localparam int MIC_PORT_EN = 3;
    localparam int MIC_T0_FLAG = 2;
    localparam int MIC_EXT_FLAG = 1;
    localparam int MIC_PORT_FLAG = 0;
    // ==========================================================
    // Peripheral flag and enable fields, option register edge bit
    localparam int MIC_EE = 7;
    localparam int MIC_AD = 6;
    localparam int MIC_CM = 3;
    localparam int MIC_T1 = 0;
    localparam logic [7:0] MIC_PMASK = 8'hc9;
    localparam int MIC_EDGE = 6;
    // Status register fields
    localparam int MIC_ST_REQ = 0;
    localparam int MIC_ST_BUSY = 1;
    localparam int MIC_ST_WAKE = 2;
    // ==========================================================
    // Reset values and constants
    localparam logic [7:0] MIC_CTRL_RST = 8'h00;
    localparam logic [7:0] MIC_PFLAG_RST = 8'h00;
    localparam logic [7:0] MIC_PEN_RST = 8'h00;
    localparam logic MIC_EDGE_RST = 1'b1;
    localparam logic [12:0] MIC_VECTOR = 13'h0004;
    localparam logic [7:0] MIC_TMR_MAX = 8'hff;
    localparam logic [7:0] MIC_TMR_MIN = 8'h00;
    localparam int MIC_GPIO_W = 6;
    // ==========================================================
    // Types
    typedef struct packed {
        logic valid;
        logic [9:0] idx;
    } mic_wr_t;
    typedef struct packed {
        logic timer0_ovf;
        logic ext_edge;
        logic port_change;
    } mic_cevt_t;
    typedef struct packed {
        logic ee_done;
        logic adc_done;
        logic cmp_change;
        logic timer1_ovf;
    } mic_pevt_t;
    typedef struct packed {
        logic push_ret;
        logic vector_load;
        logic wake;
    } mic_core_t;
    typedef enum logic [1:0] {
        MIC_IDLE = 2'b00,
        MIC_ARM = 2'b01,
        MIC_PUSH = 2'b11,
        MIC_VECT = 2'b10
    } mic_state_t;
endpackage

// >>> rtl/mic_top.sv
// Purpose: Interrupt controller of a small 8-bit core
// Assumes: One instruction cycle per hclk, core marks instruction starts
// Notes:   Zero wait state slave; flags are set-wins over bus writes
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module mic_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [2:0] hburst,
    input wire logic [3:0] hprot,
    input wire logic hmastlock,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_irq_pin,
    input wire logic [5:0] gpio_in,
    input wire logic [7:0] timer0_counter,
    input wire mic_pkg::mic_pevt_t periph_evt,
    input wire logic instr_boundary,
    input wire logic return_from_irq_instr,
    input wire logic sleep_mode,
    output mic_pkg::mic_core_t core_o,
    output logic [12:0] vector_addr
);
    import mic_pkg::*;

    // ==========================================================
    // Bus front end
    mic_wr_t wr;
    logic rd_take;
    logic [9:0] rd_idx;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_mux;

    mic_ahb_port u_port (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .rd_take(rd_take),
        .rd_idx(rd_idx),
        .wr(wr)
    );

    // Never stalls: every register access is one cycle
    assign hreadyout = 1'b1;
    assign hresp = MIC_HRESP_OKAY[0];
    assign hrdata = hrdata_reg;

    wire ctrl_wr = wr.valid && (wr.idx == MIC_IDX_CTRL);
    wire pflag_wr = wr.valid && (wr.idx == MIC_IDX_PFLAG);
    wire pen_wr = wr.valid && (wr.idx == MIC_IDX_PEN);
    wire opt_wr = wr.valid && (wr.idx == MIC_IDX_OPT);

    // ==========================================================
    // Registers
    logic glb_en_reg;
    logic peie_reg;
    logic [2:0] cen_reg;
    logic [2:0] cflag_reg;
    logic [7:0] pflag_reg;
    logic [7:0] pen_reg;
    logic edge_reg;
    logic [12:0] vec_reg;
    mic_state_t state_reg;
    mic_state_t state_next;
    logic glb_en_next;
    logic [2:0] cflag_next;
    logic [7:0] pflag_next;
    mic_cevt_t cevt;
    logic [7:0] pevt_bits;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;

    mic_event_detect u_detect (
        .hclk(hclk),
        .hresetn(hresetn),
        .ext_irq_pin(ext_irq_pin),
        .ext_edge_select(edge_reg),
        .gpio_in(gpio_in),
        .timer0_counter(timer0_counter),
        .evt(cevt)
    );

    // ==========================================================
    // Flag set logic: an event in the clearing cycle still lands
    assign pevt_bits = {periph_evt.ee_done, periph_evt.adc_done, 2'b00,
        periph_evt.cmp_change, 2'b00, periph_evt.timer1_ovf};
    assign cflag_next = (ctrl_wr ? hwdata[MIC_T0_FLAG:MIC_PORT_FLAG] : cflag_reg)
        | cevt;
    assign pflag_next = ((pflag_wr ? hwdata[7:0] : pflag_reg)
        | pevt_bits) & MIC_PMASK;

    // ==========================================================
    // Request qualification
    wire [2:0] cpend = cflag_reg & cen_reg;
    wire ppend = peie_reg && (|(pflag_reg & pen_reg));
    wire any_pend = (|cpend) || ppend;
    wire irq_req = glb_en_reg && any_pend;
    wire glb_en_drop = ctrl_wr && !hwdata[MIC_GLB_EN];
    wire take_ok = irq_req && !glb_en_drop;
    wire wake = sleep_mode && any_pend;

    // ==========================================================
    // Service sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MIC_IDLE: begin
                if (take_ok && instr_boundary) begin
                    state_next = MIC_PUSH;
                end else if (take_ok) begin
                    state_next = MIC_ARM;
                end
            end
            MIC_ARM: begin
                if (!take_ok) begin
                    state_next = MIC_IDLE;
                end else if (instr_boundary) begin
                    state_next = MIC_PUSH;
                end
            end
            MIC_PUSH: begin
                state_next = MIC_VECT;
            end
            MIC_VECT: begin
                state_next = MIC_IDLE;
            end
        endcase
    end

    always_comb begin
        glb_en_next = glb_en_reg;
        if (state_reg == MIC_PUSH) begin
            glb_en_next = 1'b0;
        end else if (return_from_irq_instr) begin
            glb_en_next = 1'b1;
        end else if (ctrl_wr) begin
            glb_en_next = hwdata[MIC_GLB_EN];
        end
    end

    assign core_o.push_ret = (state_reg == MIC_PUSH);
    assign core_o.vector_load = (state_reg == MIC_VECT);
    assign core_o.wake = wake;
    assign vector_addr = vec_reg;

    // ==========================================================
    // Read views
    assign ctrl_view = {glb_en_reg, peie_reg, cen_reg, cflag_reg};
    assign stat_view = {5'h00, wake, state_reg != MIC_IDLE, irq_req};

    always_comb begin
        rd_mux = MIC_RD_ZERO;
        unique case (rd_idx)
            MIC_IDX_CTRL: rd_mux[7:0] = ctrl_view;
            MIC_IDX_PFLAG: rd_mux[7:0] = pflag_reg;
            MIC_IDX_PEN: rd_mux[7:0] = pen_reg;
            MIC_IDX_OPT: rd_mux[MIC_EDGE] = edge_reg;
            MIC_IDX_STAT: rd_mux[7:0] = stat_view;
            default: rd_mux = MIC_RD_ZERO;
        endcase
    end

    // ==========================================================
    // State
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            glb_en_reg <= MIC_CTRL_RST[MIC_GLB_EN];
            peie_reg <= MIC_CTRL_RST[MIC_PEIE];
            cen_reg <= MIC_CTRL_RST[MIC_T0_EN:MIC_PORT_EN];
            cflag_reg <= MIC_CTRL_RST[MIC_T0_FLAG:MIC_PORT_FLAG];
            pflag_reg <= MIC_PFLAG_RST;
            pen_reg <= MIC_PEN_RST;
            edge_reg <= MIC_EDGE_RST;
            state_reg <= MIC_IDLE;
            vec_reg <= '0;
            hrdata_reg <= MIC_RD_ZERO;
        end else begin
            glb_en_reg <= glb_en_next;
            cflag_reg <= cflag_next;
            pflag_reg <= pflag_next;
            state_reg <= state_next;
            if (ctrl_wr) begin
                peie_reg <= hwdata[MIC_PEIE];
                cen_reg <= hwdata[MIC_T0_EN:MIC_PORT_EN];
            end
            if (pen_wr) begin
                pen_reg <= hwdata[7:0] & MIC_PMASK;
            end
            if (opt_wr) begin
                edge_reg <= hwdata[MIC_EDGE];
            end
            if (state_reg == MIC_PUSH) begin
                vec_reg <= MIC_VECTOR;
            end
            if (rd_take) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_push;
        state_reg == MIC_PUSH;
    endsequence
    sequence s_vector;
        core_o.vector_load && vector_addr == MIC_VECTOR && !glb_en_reg;
    endsequence

    a_service_seq: assert property (@(posedge hclk) disable iff (!hresetn)
        s_push |=> s_vector)
        else $error("service did not vector to 0004h with enable cleared");
    a_req_needs_glb: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == MIC_IDLE && !glb_en_reg |=> state_reg == MIC_IDLE)
        else $error("request taken with global enable clear");
    a_masked_src: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == MIC_IDLE && state_next != MIC_IDLE
        |-> (|(cflag_reg & cen_reg)) || (peie_reg && |(pflag_reg & pen_reg)))
        else $error("request without an enabled flag");
    a_return_sets_en: assert property (@(posedge hclk) disable iff (!hresetn)
        return_from_irq_instr && state_reg != MIC_PUSH |=> glb_en_reg)
        else $error("return did not set global enable");
    a_pin_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        (cevt.ext_edge && glb_en_reg && cen_reg[1] && state_reg == MIC_IDLE && !wr.valid)
        ##1 (instr_boundary && !wr.valid) |-> ##[1:2] core_o.vector_load)
        else $error("pin event latency out of range");
    a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        cflag_reg[MIC_EXT_FLAG] && !ctrl_wr |=> cflag_reg[MIC_EXT_FLAG])
        else $error("flag cleared by hardware");
    a_flag_regardless: assert property (@(posedge hclk) disable iff (!hresetn)
        cevt.timer0_ovf |=> cflag_reg[MIC_T0_FLAG])
        else $error("timer0 flag not set by event");
    a_wake_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        periph_evt.ee_done || periph_evt.adc_done |=> pflag_reg[MIC_EE] || pflag_reg[MIC_AD])
        else $error("peripheral flag not set by wake cause");
    a_enable_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == MIC_ARM && glb_en_drop |=> state_reg == MIC_IDLE ##1 !core_o.push_ret)
        else $error("request taken after global enable cleared");
    a_wake_vector: assert property (@(posedge hclk) disable iff (!hresetn)
        sleep_mode && take_ok && instr_boundary && state_reg == MIC_IDLE
        |=> s_push ##1 s_vector)
        else $error("wake-up with enable set did not vector");
endmodule
